// ---- hdl/acs_pkg.sv ----
// package: constants and types for the converter sequencing block
package acs_pkg;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned SAMPLE_NS     = 800;
  localparam int unsigned CONV_NS       = 650;
  localparam int unsigned SAMPLE_CYC    = (SAMPLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CONV_CYC      = (CONV_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W         = 8;
  localparam logic [1:0]  SRC_SUBMAIN   = 2'h3;
  localparam logic [1:0]  SEQ_SINGLE    = 2'h0;
  localparam logic [15:0] CAL_LO        = 16'h1a1a;
  localparam logic [15:0] CAL_HI        = 16'h1a25;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_CONV   = 4'h4,
    ST_HALT   = 4'h8
  } acs_state_e;

  typedef struct packed {
    logic       enable;
    logic       powerOn;
    logic       swStart;
    logic       samplePulse;
    logic [1:0] seqMode;
    logic [1:0] clkSrc;
    logic [2:0] clkDiv;
    logic       subMainOff;
    logic       swTrigSel;
  } acs_ctrl_s;
endpackage

// ---- hdl/acs_sequencer.sv ----
// converter start, busy, halt and hang sequencing logic
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // control bits
  input  wire acs_ctrl_s   ctrl,
  input  wire logic        ctrlWrite,
  input  wire logic        timerTrig,
  // calibration write attempt
  input  wire logic        calWrite,
  input  wire logic [15:0] calAddr,
  // status
  output logic             conversionBusyFlag,
  output logic             softwareStartPending,
  output logic             conversionDone,
  output logic             halted,
  output logic             hung,
  output logic             calWriteRefused
);

  acs_state_e       state;
  acs_state_e       next_state;
  logic [CNT_W-1:0] cnt;
  acs_ctrl_s        prevCtrl;
  logic             lastTrigHw;
  logic             scPend;
  logic [CNT_W-1:0] busyLen;

  function automatic logic oddDivide(input logic [2:0] d);
    return (d == 3'h2) || (d == 3'h4) || (d == 3'h6);
  endfunction

  wire logic powerToggle  = ctrlWrite && (ctrl.powerOn != prevCtrl.powerOn);
  wire logic multiMode    = ctrl.seqMode != SEQ_SINGLE;
  wire logic enRise       = ctrlWrite && ctrl.enable && !prevCtrl.enable;
  wire logic scRise       = ctrlWrite && ctrl.swStart && !prevCtrl.swStart;
  wire logic srcLeave     = ctrlWrite && (prevCtrl.clkSrc == SRC_SUBMAIN)
                            && (ctrl.clkSrc != SRC_SUBMAIN);
  // odd divide clock hang
  // hang condition
  wire logic clkHangHit   = srcLeave && prevCtrl.subMainOff && oddDivide(prevCtrl.clkDiv);
  // simultaneous enable and start after hardware trigger
  wire logic scHangHit    = enRise && scRise && lastTrigHw;
  wire logic busyNow      = (state == ST_SAMPLE) || (state == ST_CONV);
  wire logic trigReq      = ctrl.swTrigSel ? (scRise || scPend) : timerTrig;
  wire logic startOk      = ctrl.powerOn && ctrl.enable && trigReq && !hung && !scHangHit;
  wire logic cntDone      = cnt == '0;
  wire logic calHit       = calWrite && (calAddr >= CAL_LO) && (calAddr <= CAL_HI);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   if (startOk) next_state = ST_SAMPLE;
      ST_SAMPLE: if (cntDone) next_state = ST_CONV;
      ST_CONV: begin
        if (cntDone) next_state = ST_IDLE;
      end
      ST_HALT:   next_state = ST_HALT;
      default:   next_state = ST_IDLE;
    endcase
    if (busyNow && powerToggle && multiMode) next_state = ST_HALT;
    if (state == ST_HALT && ctrlWrite && !ctrl.enable && !ctrl.powerOn) next_state = ST_IDLE;
    if (hung || clkHangHit) next_state = ST_HALT;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      cnt        <= '0;
      prevCtrl   <= '0;
      lastTrigHw <= 1'b0;
      scPend     <= 1'b0;
      hung       <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      if (ctrlWrite) prevCtrl <= ctrl;
      if (ctrlWrite) lastTrigHw <= !ctrl.swTrigSel ? 1'b1 : (lastTrigHw && !startOk);
      // only a device reset clears the hang
      if (clkHangHit || scHangHit) hung <= 1'b1;
      // start bit never self-clears once hung
      scPend <= (scRise || scPend) && !startOk && !(state == ST_HALT && !hung);
      if (state == ST_IDLE && startOk) cnt <= CNT_W'(SAMPLE_CYC - 1);
      else if (state == ST_SAMPLE && cntDone) cnt <= CNT_W'(CONV_CYC - 1);
      else if (!cntDone) cnt <= cnt - 1'b1;
    end
  end

  // busy from start to conversion end; stuck high on hang while the start bit is pending
  assign conversionBusyFlag   = busyNow || (hung && scPend);
  assign softwareStartPending = scPend;
  assign conversionDone       = (state == ST_CONV) && cntDone && clkEn && !hung;
  assign halted               = state == ST_HALT;
  assign calWriteRefused      = calHit;

  // assertion helper: cycles spent busy in one conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      busyLen <= '0;
    end else if (clkEn) begin
      busyLen <= busyNow ? busyLen + 1'b1 : '0;
    end
  end

  a_busy_covers: assert property (@(posedge clk) disable iff (rst)
    (state == ST_SAMPLE) |-> conversionBusyFlag)
    else $error("busy low during sample");

  a_hang_sticky: assert property (@(posedge clk) disable iff (rst)
    hung |=> hung)
    else $error("hang released without reset");

  a_clk_hang: assert property (@(posedge clk) disable iff (rst)
    (clkEn && clkHangHit) |=> hung && halted)
    else $error("clock hang not entered");

  a_sc_hang: assert property (@(posedge clk) disable iff (rst)
    (clkEn && scHangHit) |=> hung)
    else $error("simultaneous start did not hang");

  a_toggle_halt: assert property (@(posedge clk) disable iff (rst)
    (clkEn && busyNow && powerToggle && multiMode) |=> halted)
    else $error("power toggle did not halt");

  a_cal_refuse: assert property (@(posedge clk) disable iff (rst)
    (calWrite && calAddr == CAL_LO) |-> calWriteRefused)
    else $error("calibration write accepted");

  a_cal_top: assert property (@(posedge clk) disable iff (rst)
    (calWrite && calAddr == CAL_HI) |-> calWriteRefused)
    else $error("calibration top write accepted");

  a_cal_outside: assert property (@(posedge clk) disable iff (rst)
    (calWrite && (calAddr == CAL_LO - 16'h1 || calAddr == CAL_HI + 16'h1))
    |-> !calWriteRefused)
    else $error("write outside calibration range refused");

  a_no_done_hung: assert property (@(posedge clk) disable iff (rst)
    hung |-> !conversionDone)
    else $error("conversion finished while hung");

  a_idle_busy: assert property (@(posedge clk) disable iff (rst)
    (state == ST_IDLE && !hung) |-> !conversionBusyFlag)
    else $error("busy high while idle");

  a_busy_length: assert property (@(posedge clk) disable iff (rst)
    conversionDone |-> busyLen == CNT_W'(SAMPLE_CYC + CONV_CYC - 1))
    else $error("conversion length wrong");

  a_done_pulse: assert property (@(posedge clk) disable iff (rst)
    conversionDone |=> !conversionDone)
    else $error("done longer than one cycle");

  a_start_busy: assert property (@(posedge clk) disable iff (rst)
    (clkEn && state == ST_IDLE && startOk && !clkHangHit) |=> conversionBusyFlag)
    else $error("busy missing after start");

  a_busy_refuse: assert property (@(posedge clk) disable iff (rst)
    (clkEn && state == ST_SAMPLE && !cntDone && !(powerToggle && multiMode)
     && !clkHangHit && !hung) |=> state == ST_SAMPLE)
    else $error("sample phase cut short");

  // hang keeps busy and start bit
  a_hang_busy: assert property (@(posedge clk) disable iff (rst)
    (hung && scPend) |=> conversionBusyFlag && softwareStartPending)
    else $error("hung start bit cleared");

  a_halt_stays: assert property (@(posedge clk) disable iff (rst)
    (halted && !(clkEn && ctrlWrite && !ctrl.enable && !ctrl.powerOn)) |=> halted)
    else $error("halt left without recovery");

  a_halt_release: assert property (@(posedge clk) disable iff (rst)
    (clkEn && halted && !hung && !clkHangHit && ctrlWrite && !ctrl.enable
     && !ctrl.powerOn) |=> !halted)
    else $error("recovery write ignored");

  // even or unit divide switch safe
  a_even_switch: assert property (@(posedge clk) disable iff (rst)
    (clkEn && srcLeave && !oddDivide(prevCtrl.clkDiv) && !hung && !scHangHit) |=> !hung)
    else $error("hang on safe clock switch");

  a_freeze: assert property (@(posedge clk) disable iff (rst)
    !clkEn |=> $stable({state, cnt, hung, scPend}))
    else $error("state moved while frozen");

  c_done:   cover property (@(posedge clk) conversionDone);
  c_halt:   cover property (@(posedge clk) !halted ##1 halted);
  c_hung:   cover property (@(posedge clk) !hung ##1 hung);
  c_cal:    cover property (@(posedge clk) calWriteRefused);
  c_sw:     cover property (@(posedge clk) scRise && startOk);

endmodule
`default_nettype wire

// ---- verification/acs_sequencer_tb.sv ----
// self-checking testbench for the converter sequencing block
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_tb;
  import acs_pkg::*;
  logic        clk, rst, clkEn, ctrlWrite, timerTrig, calWrite;
  logic [15:0] calAddr;
  acs_ctrl_s   ctrl;
  logic        busy, pend, done, halted, hung, refused;
  int          errorCnt, nCompared, k;
  logic [15:0] ad [4] = '{16'h1a19, CAL_LO, CAL_HI, 16'h1a26};
  acs_sequencer acs_sequencer_i (.clk(clk), .rst(rst), .clkEn(clkEn), .ctrl(ctrl),
    .ctrlWrite(ctrlWrite), .timerTrig(timerTrig), .calWrite(calWrite), .calAddr(calAddr),
    .conversionBusyFlag(busy), .softwareStartPending(pend), .conversionDone(done),
    .halted(halted), .hung(hung), .calWriteRefused(refused));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    nCompared++;
    if (s !== e) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic completeRun();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rsth();
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
  endtask
  // one software write of the control bits
  task automatic wr(input logic en, pw, sc, trg, input logic [1:0] seq, src,
                    input logic [2:0] dv, input logic off);
    @(negedge clk);
    ctrl = '{en, pw, sc, 1'b0, seq, src, dv, off, trg};
    ctrlWrite = 1'b1;
    @(negedge clk);
    ctrlWrite = 1'b0;
  endtask
  task automatic conv(input logic viaTimer);
    k = 0;
    if (viaTimer) begin
      timerTrig = 1'b1;
      @(negedge clk);
      timerTrig = 1'b0;
    end
    while (busy !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    chk("busy rise", busy, 8'h1);
    for (k = 0; done !== 1'b1 && busy === 1'b1 && k < 99; k++) @(negedge clk);
    chk("conversion cycles", 8'(k + 1), 8'(SAMPLE_CYC + CONV_CYC));
    // busy seen low before the next start
    @(negedge clk);
    chk("busy fall", busy, 8'h0);
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    errorCnt++;
    completeRun();
  end
  initial begin
    {rst, clkEn, ctrl, ctrlWrite, timerTrig, calWrite, calAddr} = '0;
    clkEn = 1'b1;
    rsth();
    chk("reset outputs", {busy, pend, done, halted, hung, refused}, 8'h0);
    wr(1, 1, 0, 1, SEQ_SINGLE, 2'h0, 3'h0, 0);
    wr(1, 1, 1, 1, SEQ_SINGLE, 2'h0, 3'h0, 0);
    conv(0);
    chk("start self-clear", pend, 8'h0);
    $display("software conversion test done");
    calWrite = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      calAddr = ad[i];
      #5 chk("calibration refuse", refused, 8'(i == 1 || i == 2));
    end
    calWrite = 1'b0;
    $display("calibration test done");
    wr(1, 1, 0, 1, 2'h1, 2'h0, 3'h0, 0);
    wr(1, 1, 1, 1, 2'h1, 2'h0, 3'h0, 0);
    repeat (4) @(negedge clk);
    wr(1, 0, 0, 1, 2'h1, 2'h0, 3'h0, 0);
    wr(1, 1, 0, 1, 2'h1, 2'h0, 3'h0, 0);
    repeat (40) @(negedge clk);
    chk("halt", halted, 8'h1);
    wr(0, 0, 0, 1, SEQ_SINGLE, 2'h0, 3'h0, 0);
    chk("halt cleared", halted, 8'h0);
    wr(0, 1, 0, 1, SEQ_SINGLE, 2'h0, 3'h0, 0);
    wr(1, 1, 0, 1, SEQ_SINGLE, 2'h0, 3'h0, 0);
    wr(1, 1, 1, 1, SEQ_SINGLE, 2'h0, 3'h0, 0);
    conv(0);
    $display("halt and recovery test done");
    wr(1, 1, 0, 1, 2'h1, 2'h0, 3'h0, 0);
    wr(1, 1, 1, 1, 2'h1, 2'h0, 3'h0, 0);
    wr(0, 1, 0, 1, 2'h1, 2'h0, 3'h0, 0);
    for (k = 0; busy === 1'b1 && k < 99; k++) @(negedge clk);
    wr(0, 0, 0, 1, 2'h1, 2'h0, 3'h0, 0);
    chk("no halt after safe toggle", halted, 8'h0);
    $display("safe power toggle test done");
    wr(1, 1, 0, 0, SEQ_SINGLE, 2'h0, 3'h0, 0);
    conv(1);
    wr(0, 1, 0, 0, SEQ_SINGLE, 2'h0, 3'h0, 0);
    wr(1, 1, 1, 1, SEQ_SINGLE, 2'h0, 3'h0, 0);
    repeat (40) @(negedge clk);
    chk("hang", {hung, busy, pend}, 8'h7);
    rsth();
    chk("hang reset", {hung, busy}, 8'h0);
    $display("simultaneous start test done");
    wr(0, 1, 0, 1, SEQ_SINGLE, SRC_SUBMAIN, 3'h3, 1);
    wr(0, 1, 0, 1, SEQ_SINGLE, 2'h0, 3'h3, 1);
    chk("even divide switch", hung, 8'h0);
    wr(0, 1, 0, 1, SEQ_SINGLE, SRC_SUBMAIN, 3'h2, 1);
    wr(0, 1, 0, 1, SEQ_SINGLE, 2'h0, 3'h2, 1);
    repeat (2) @(negedge clk);
    chk("odd divide hang", hung, 8'h1);
    rsth();
    $display("clock switch test done");
    completeRun();
  end
endmodule
`default_nettype wire
